// ===== src/rxbw_top.sv
`timescale 1ns/100ps
// Functional notes
// - rx interrupt on packet count or timeout
// - set either normal or alternate rx flag
// - 16-bit rx timer in two bytes, 25 MHz
// - rx timer zero disables timeout interrupts
// - timer starts after packet moved, resets on interrupt
// - count field 7:6 selects 1,2,4,8 packets
// - count independent of timer; 00 per packet
// - 8-bit bus timeout counter at 25 MHz
// - bus timeout zero disables the check
// - timer starts with cycle, clears on completion
// - overlong host cycle is forcibly terminated
// - bus timeout sets status bit 6
// - fragment count decrements by DMA bytes, compares length
// - hold DMA request while packet exceeds count
// - fragment flag on packet done during holdoff, masked interrupt
// - fragment count in three bytes, reset zero
// - zero fragment count disables its logic
// - DMA request only with four transfers ready
module rxbw_top #(
  parameter int FRAG_W = 24,
  parameter int LEN_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // block events
  input wire rxbw_pkg::rxbw_rx_evt_t rx_evt,
  input wire rxbw_pkg::rxbw_bus_t bus_cyc,
  input wire rxbw_pkg::rxbw_dma_t dma,
  // block outputs
  output logic host_cycle_abort,
  output logic host_dma_request_n,
  output logic irq
);
  import rxbw_pkg::*;

  // the comparison is made on the full 24-bit counter width
  if (FRAG_W < LEN_W || FRAG_W > 24 || LEN_W < 1) begin : g_bad_width
    $error("rxbw_top: FRAG_W must be LEN_W..24");
  end

  logic [7:0] rx_pkt_cfg_reg;
  logic [7:0] evt_mask_reg;
  logic [7:0] evt_status_reg;
  logic [7:0] evt_status_next;
  logic [15:0] rx_irq_timer_reg;
  logic [7:0] bus_cycle_timeout_reg;
  logic [23:0] frag_reg;
  logic [23:0] frag_next;
  logic [5:0] tick_acc_reg;
  logic tick;
  logic [3:0] pend_reg;
  logic [3:0] target;
  logic err_seen_reg;
  logic tmr_run_reg;
  logic [15:0] tmr_cnt_reg;
  logic pkt_evt;
  logic fire_cnt;
  logic fire_tmr;
  logic rx_fire;
  logic bus_active_reg;
  logic [7:0] bus_cnt_reg;
  logic bus_expire;
  logic frag_en;
  logic holdoff;
  logic [7:0] idx;
  logic addr_ok;
  logic mapped;
  logic wr_en;
  logic [7:0] wbyte;
  logic [31:0] rd_mux;

  // apb decode; zero wait states, unmapped index errors
  assign idx = paddr[9:2];
  assign addr_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (idx)
      IDX_RX_PKT_CFG: rd_mux[7:0] = rx_pkt_cfg_reg;
      IDX_EVT_MASK: rd_mux[7:0] = evt_mask_reg;
      IDX_EVT_STATUS: rd_mux[7:0] = evt_status_reg;
      IDX_RX_TMR_LOW: rd_mux[7:0] = rx_irq_timer_reg[7:0];
      IDX_RX_TMR_HIGH: rd_mux[7:0] = rx_irq_timer_reg[15:8];
      IDX_BUS_TIMEOUT: rd_mux[7:0] = bus_cycle_timeout_reg;
      IDX_FRAG_0: rd_mux[7:0] = frag_reg[7:0];
      IDX_FRAG_1: rd_mux[7:0] = frag_reg[15:8];
      IDX_FRAG_2: rd_mux[7:0] = frag_reg[23:16];
      IDX_BLOCK_STATE: rd_mux[7:0] = {holdoff, bus_active_reg, tmr_run_reg, err_seen_reg, pend_reg};
      default: mapped = 1'b0;
    endcase
    if (!addr_ok) begin
      mapped = 1'b0;
      rd_mux = 32'h0000_0000;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  // only lane 0 carries register data; other lanes are ignored
  assign wr_en = psel && penable && pwrite && mapped && pstrb[0];
  assign wbyte = pwdata[7:0];

  // read data is captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_pkt_cfg_reg <= RST_BYTE;
      evt_mask_reg <= RST_BYTE;
      rx_irq_timer_reg <= RST_RX_TMR;
      bus_cycle_timeout_reg <= RST_BUS_TO;
    end else if (wr_en) begin
      if (idx == IDX_RX_PKT_CFG) begin
        rx_pkt_cfg_reg <= wbyte;
      end
      if (idx == IDX_EVT_MASK) begin
        evt_mask_reg <= wbyte;
      end
      if (idx == IDX_RX_TMR_LOW) begin
        rx_irq_timer_reg[7:0] <= wbyte;
      end
      if (idx == IDX_RX_TMR_HIGH) begin
        rx_irq_timer_reg[15:8] <= wbyte;
      end
      if (idx == IDX_BUS_TIMEOUT) begin
        bus_cycle_timeout_reg <= wbyte;
      end
    end
  end

  // 25 MHz tick by fractional accumulation; ticks are not evenly spaced
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_acc_reg <= 6'h00;
    end else if (tick) begin
      tick_acc_reg <= tick_acc_reg + TICK_INC - TICK_MOD;
    end else begin
      tick_acc_reg <= tick_acc_reg + TICK_INC;
    end
  end
  assign tick = (tick_acc_reg + TICK_INC) >= TICK_MOD;

  // receive interrupt moderation
  assign pkt_evt = rx_pkt_cfg_reg[START_SEL_BIT] ? rx_evt.to_host : rx_evt.to_mem;
  assign target = 4'h1 << rx_pkt_cfg_reg[PKT_CNT_LSB +: 2];
  assign fire_cnt = pkt_evt && ((pend_reg + 4'h1) >= target);
  assign fire_tmr = tmr_run_reg && !pkt_evt && (rx_irq_timer_reg != 16'h0000) && tick &&
                    ((tmr_cnt_reg + 16'h0001) >= rx_irq_timer_reg);
  assign rx_fire = fire_cnt || fire_tmr;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_reg <= 4'h0;
      err_seen_reg <= 1'b0;
    end else if (rx_fire) begin
      pend_reg <= 4'h0;
      err_seen_reg <= 1'b0;
    end else if (pkt_evt) begin
      pend_reg <= pend_reg + 4'h1;
      err_seen_reg <= err_seen_reg || rx_evt.err;
    end
  end

  // timer restarts on every counted packet and stops when the interrupt fires
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_run_reg <= 1'b0;
      tmr_cnt_reg <= 16'h0000;
    end else if (rx_fire) begin
      tmr_run_reg <= 1'b0;
      tmr_cnt_reg <= 16'h0000;
    end else if (pkt_evt) begin
      tmr_run_reg <= 1'b1;
      tmr_cnt_reg <= 16'h0000;
    end else if (tmr_run_reg && tick) begin
      tmr_cnt_reg <= tmr_cnt_reg + 16'h0001;
    end
  end

  // bus integrity watchdog
  assign bus_expire = bus_active_reg && !bus_cyc.done && (bus_cycle_timeout_reg != 8'h00) && tick &&
                      ((bus_cnt_reg + 8'h01) >= bus_cycle_timeout_reg);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_active_reg <= 1'b0;
      bus_cnt_reg <= 8'h00;
    end else if (bus_cyc.start) begin
      bus_active_reg <= 1'b1;
      bus_cnt_reg <= 8'h00;
    end else if (bus_cyc.done || bus_expire) begin
      bus_active_reg <= 1'b0;
      bus_cnt_reg <= 8'h00;
    end else if (bus_active_reg && tick) begin
      bus_cnt_reg <= bus_cnt_reg + 8'h01;
    end
  end

  // abort is a one-cycle pulse to the host bus interface
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_cycle_abort <= 1'b0;
    end else begin
      host_cycle_abort <= bus_expire;
    end
  end

  // fragment counter; a software write beats a same-cycle decrement
  assign frag_en = frag_reg != 24'h00_0000;
  assign holdoff = frag_en && dma.next_valid && (24'(dma.next_len) > frag_reg);
  always_comb begin
    frag_next = frag_reg;
    if (frag_en && dma.byte_valid) begin
      if (frag_reg > 24'(dma.bytes)) begin
        frag_next = frag_reg - 24'(dma.bytes);
      end else begin
        frag_next = 24'h00_0000;
      end
    end
    if (wr_en && idx == IDX_FRAG_0) begin
      frag_next[7:0] = wbyte;
    end
    if (wr_en && idx == IDX_FRAG_1) begin
      frag_next[15:8] = wbyte;
    end
    if (wr_en && idx == IDX_FRAG_2) begin
      frag_next[23:16] = wbyte;
    end
    if (FRAG_W < 24) begin
      frag_next = frag_next & ((24'h00_0001 << FRAG_W) - 24'h00_0001);
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frag_reg <= 24'h00_0000;
    end else begin
      frag_reg <= frag_next;
    end
  end

  // event status: hardware set wins over a write-one clear
  always_comb begin
    evt_status_next = evt_status_reg;
    if (wr_en && idx == IDX_EVT_STATUS) begin
      evt_status_next = evt_status_reg & ~wbyte;
    end
    if (rx_fire) begin
      if (err_seen_reg || (pkt_evt && rx_evt.err)) begin
        evt_status_next[RX_ALT_BIT] = 1'b1;
      end else begin
        evt_status_next[RX_DONE_BIT] = 1'b1;
      end
    end
    if (bus_expire) begin
      evt_status_next[BUS_TO_BIT] = 1'b1;
    end
    if (dma.pkt_done && frag_en && holdoff) begin
      evt_status_next[FRAG_BIT] = 1'b1;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_status_reg <= RST_BYTE;
    end else begin
      evt_status_reg <= evt_status_next;
    end
  end

  // request needs a full burst and room in the host buffer
  assign host_dma_request_n = !((dma.ready_cnt >= BURST_WORDS) && !holdoff);
  assign irq = |(evt_status_reg & evt_mask_reg);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RX_COUNT_FIRE: assert property (fire_cnt |=> evt_status_reg[RX_DONE_BIT] || evt_status_reg[RX_ALT_BIT])
    else $error("packet count reached without rx flag");
  AST_RX_ONE_FLAG: assert property (rx_fire && !err_seen_reg && !rx_evt.err |=> evt_status_reg[RX_DONE_BIT])
    else $error("clean rx batch did not set normal flag");
  AST_RX_TMR_OFF: assert property (rx_irq_timer_reg == 16'h0000 |-> !fire_tmr)
    else $error("timeout fired while rx timer disabled");
  AST_RX_TMR_RESET: assert property (rx_fire |=> !tmr_run_reg && tmr_cnt_reg == 16'h0000)
    else $error("rx timer not reset by interrupt");
  AST_RX_TARGET: assert property (pkt_evt && rx_pkt_cfg_reg[7:6] == 2'b11 && pend_reg == 4'h7 |-> rx_fire)
    else $error("eighth packet did not fire");
  AST_RX_SINGLE: assert property (pkt_evt && rx_pkt_cfg_reg[7:6] == 2'b00 |-> rx_fire)
    else $error("default count did not fire per packet");
  AST_BUS_ABORT: assert property (bus_expire |=> host_cycle_abort && evt_status_reg[BUS_TO_BIT] && !bus_active_reg)
    else $error("bus timeout did not abort and flag");
  AST_BUS_OFF: assert property (bus_cycle_timeout_reg == 8'h00 |=> !host_cycle_abort)
    else $error("abort while bus check disabled");
  AST_BUS_DONE: assert property (bus_cyc.done && !bus_cyc.start |=> !bus_active_reg ##1 !host_cycle_abort)
    else $error("completed cycle still watched");
  AST_FRAG_HOLD: assert property (holdoff |-> host_dma_request_n)
    else $error("dma request during fragment holdoff");
  AST_FRAG_IDLE: assert property (frag_reg == 24'h00_0000 && !wr_en |=> frag_reg == 24'h00_0000 && !holdoff)
    else $error("zero fragment counter not idle");
  AST_DREQ_BURST: assert property (!host_dma_request_n |-> dma.ready_cnt >= BURST_WORDS)
    else $error("dma request without four transfers ready");
  // a mask write can raise irq, but only a status or mask write may drop it
  AST_IRQ_FOLLOW: assert property ($fell(irq) |->
    $past(wr_en && (idx == IDX_EVT_STATUS || idx == IDX_EVT_MASK)))
    else $error("irq fell without a status or mask write");

  COV_RX_TIMEOUT: cover property (fire_tmr ##1 evt_status_reg[RX_DONE_BIT]);
  COV_BUS_ABORT: cover property (bus_cyc.start ##[1:300] host_cycle_abort);
  COV_FRAG_FLAG: cover property (holdoff ##[1:50] evt_status_reg[FRAG_BIT]);
  COV_DREQ_RESUME: cover property (holdoff ##[1:100] !host_dma_request_n);

endmodule : rxbw_top

// ===== src/rxbw_pkg.sv
package rxbw_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RX_PKT_CFG = 8'h01;
  localparam logic [7:0] IDX_EVT_MASK = 8'h08;
  localparam logic [7:0] IDX_EVT_STATUS = 8'h09;
  localparam logic [7:0] IDX_RX_TMR_LOW = 8'h14;
  localparam logic [7:0] IDX_RX_TMR_HIGH = 8'h15;
  localparam logic [7:0] IDX_BUS_TIMEOUT = 8'h1D;
  localparam logic [7:0] IDX_FRAG_0 = 8'h54;
  localparam logic [7:0] IDX_FRAG_1 = 8'h55;
  localparam logic [7:0] IDX_FRAG_2 = 8'h56;
  localparam logic [7:0] IDX_BLOCK_STATE = 8'h60;
  // field positions
  localparam int PKT_CNT_LSB = 6;
  localparam int START_SEL_BIT = 5;
  localparam int FRAG_BIT = 0;
  localparam int RX_DONE_BIT = 1;
  localparam int RX_ALT_BIT = 2;
  localparam int BUS_TO_BIT = 6;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_RX_TMR = 16'h0000;
  localparam logic [7:0] RST_BUS_TO = 8'h00;
  // timer tick: 25 MHz timebase made from the 40 MHz clock
  localparam int CLK_KHZ = 40000;
  localparam int TIMER_KHZ = 25000;
  localparam int TIMER_PERIOD_NS = 40;
  localparam int TICK_GCD = 5000;
  localparam logic [5:0] TICK_INC = 6'(TIMER_KHZ / TICK_GCD);
  localparam logic [5:0] TICK_MOD = 6'(CLK_KHZ / TICK_GCD);
  localparam logic [2:0] BURST_WORDS = 3'h4;
  // receive packet events from the local and host DMA
  typedef struct packed {
    logic to_mem;
    logic to_host;
    logic err;
  } rxbw_rx_evt_t;
  // host bus cycle tracking
  typedef struct packed {
    logic start;
    logic done;
  } rxbw_bus_t;
  // host receive DMA status
  typedef struct packed {
    logic byte_valid;
    logic [2:0] bytes;
    logic pkt_done;
    logic next_valid;
    logic [15:0] next_len;
    logic [2:0] ready_cnt;
  } rxbw_dma_t;
endpackage : rxbw_pkg

// ===== tb/rxbw_host_model.sv
`timescale 1ns/100ps
module rxbw_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // commands from the bench
  input wire logic cyc_go,
  input wire logic [7:0] cyc_len,
  input wire logic xfer_go,
  input wire logic [2:0] xfer_bytes,
  input wire logic pkt_end,
  input wire logic [15:0] pkt_len,
  input wire logic [2:0] rdy,
  // block side
  input wire logic host_cycle_abort,
  input wire logic host_dma_request_n,
  output rxbw_pkg::rxbw_bus_t bus_cyc,
  output rxbw_pkg::rxbw_dma_t dma,
  output logic [7:0] n_abort
);
  import rxbw_pkg::*;
  logic busy;
  logic [7:0] cnt;
  logic bv;
  logic pd;
  // a host cycle runs cyc_len clocks unless the block cuts it short
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_cyc <= '0;
      busy <= 1'b0;
      cnt <= 8'h00;
    end else begin
      bus_cyc <= '0;
      if (cyc_go && !busy) begin
        bus_cyc.start <= 1'b1;
        busy <= 1'b1;
        cnt <= 8'h00;
      end else if (busy && host_cycle_abort) begin
        busy <= 1'b0;
      end else if (busy && cnt + 8'h01 == cyc_len) begin
        bus_cyc.done <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
  // every abort is counted, so a spurious one shows up too
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      n_abort <= 8'h00;
    end else if (host_cycle_abort) begin
      n_abort <= n_abort + 8'h01;
    end
  end
  // host dma moves bytes only while the request is asserted
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bv <= 1'b0;
      pd <= 1'b0;
    end else begin
      bv <= xfer_go && !host_dma_request_n;
      pd <= pkt_end;
    end
  end
  assign dma = {bv, xfer_bytes, pd, pkt_len != 16'h0000, pkt_len, rdy};
endmodule : rxbw_host_model

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import rxbw_pkg::*;
  // stimulus, observed outputs and the expected-read queue
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, host_cycle_abort, host_dma_request_n, irq;
  rxbw_rx_evt_t rx_evt = '0;
  rxbw_bus_t bus_cyc;
  rxbw_dma_t dma;
  logic cyc_go = 1'b0, xfer_go = 1'b0, pkt_end = 1'b0;
  logic [7:0] cyc_len = 8'h00, n_abort, v;
  logic [2:0] rdy = 3'h4;
  logic [15:0] pkt_len = 16'h0000;
  logic [32:0] exp_q[$];
  logic [7:0] regs [7] = '{IDX_RX_PKT_CFG, IDX_RX_TMR_LOW, IDX_RX_TMR_HIGH, IDX_BUS_TIMEOUT,
                           IDX_FRAG_0, IDX_FRAG_1, IDX_FRAG_2};
  int miscompares = 0, n_tests = 0, seed = 10888;
  initial begin
    forever #12.5 clk = ~clk;
  end
  rxbw_top dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_evt(rx_evt), .bus_cyc(bus_cyc), .dma(dma), .host_cycle_abort(host_cycle_abort),
    .host_dma_request_n(host_dma_request_n), .irq(irq));
  rxbw_host_model host_u (.clk(clk), .sys_rst(sys_rst), .cyc_go(cyc_go), .cyc_len(cyc_len),
    .xfer_go(xfer_go), .xfer_bytes(3'h4), .pkt_end(pkt_end), .pkt_len(pkt_len), .rdy(rdy),
    .host_cycle_abort(host_cycle_abort), .host_dma_request_n(host_dma_request_n),
    .bus_cyc(bus_cyc), .dma(dma), .n_abort(n_abort));
  task automatic give_verdict;
    if (miscompares == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, idx, 8'h00);
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  task automatic pkt(input logic m, input logic h, input logic e);
    @(posedge clk);
    rx_evt <= '{to_mem: m, to_host: h, err: e};
    @(posedge clk);
    rx_evt <= '0;
  endtask : pkt
  // read data and error flag are judged at the access edge, oldest note first
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    step(10);
    sys_rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 33'h0);
    rd(8'h3F, {1'b1, 32'h0});
    // packet count targets 1, 2, 4 and 8 with the timer off
    wr(IDX_EVT_MASK, 8'h06);
    for (int s = 0; s < 4; s++) begin
      wr(IDX_RX_PKT_CFG, 8'(s << PKT_CNT_LSB));
      repeat ((1 << s) - 1) pkt(1'b1, 1'b0, 1'b0);
      step(40);
      rd(IDX_EVT_STATUS, 33'h0);
      pkt(1'b1, 1'b0, 1'b0);
      rd(IDX_EVT_STATUS, 33'h2);
      chk(33'(irq), 33'h1);
      wr(IDX_EVT_STATUS, 8'hFF);
      step(1);
      chk(33'(irq), 33'h0);
    end
    wr(IDX_RX_PKT_CFG, 8'h00);
    pkt(1'b1, 1'b0, 1'b1);
    rd(IDX_EVT_STATUS, 33'h4);
    wr(IDX_EVT_STATUS, 8'hFF);
    // host-memory select ignores packet-memory moves
    wr(IDX_RX_PKT_CFG, 8'h20);
    pkt(1'b1, 1'b0, 1'b0);
    rd(IDX_EVT_STATUS, 33'h0);
    pkt(1'b0, 1'b1, 1'b0);
    rd(IDX_EVT_STATUS, 33'h2);
    wr(IDX_EVT_STATUS, 8'hFF);
    // 8-packet target, 256-tick timer: one packet fires by timeout near 410 clocks
    wr(IDX_RX_PKT_CFG, 8'hC0);
    wr(IDX_RX_TMR_HIGH, 8'h01);
    pkt(1'b1, 1'b0, 1'b0);
    step(300);
    rd(IDX_EVT_STATUS, 33'h0);
    step(150);
    rd(IDX_EVT_STATUS, 33'h2);
    wr(IDX_EVT_STATUS, 8'hFF);
    wr(IDX_RX_TMR_HIGH, 8'h00);
    // long host cycle with the watchdog off, then 10 ticks
    cyc_len <= 8'hC8;
    cyc_go <= 1'b1;
    step(1);
    cyc_go <= 1'b0;
    step(220);
    chk(33'(n_abort), 33'h0);
    wr(IDX_BUS_TIMEOUT, 8'h0A);
    cyc_len <= 8'h05;
    cyc_go <= 1'b1;
    step(1);
    cyc_go <= 1'b0;
    step(20);
    chk(33'(n_abort), 33'h0);
    cyc_len <= 8'hC8;
    cyc_go <= 1'b1;
    step(1);
    cyc_go <= 1'b0;
    step(12);
    chk(33'(n_abort), 33'h0);
    step(18);
    chk(33'(n_abort), 33'h1);
    rd(IDX_EVT_STATUS, 33'h40);
    wr(IDX_EVT_STATUS, 8'hFF);
    wr(IDX_BUS_TIMEOUT, 8'h00);
    // fragment counter: off at zero, holdoff below packet length, reload
    pkt_len <= 16'h0064;
    step(2);
    chk(33'(host_dma_request_n), 33'h0);
    rdy <= 3'h3;
    step(2);
    chk(33'(host_dma_request_n), 33'h1);
    rdy <= 3'h4;
    wr(IDX_FRAG_0, 8'h50);
    step(1);
    chk(33'(host_dma_request_n), 33'h1);
    rd(IDX_BLOCK_STATE, 33'h80);
    pkt_end <= 1'b1;
    step(1);
    pkt_end <= 1'b0;
    step(2);
    rd(IDX_EVT_STATUS, 33'h1);
    chk(33'(irq), 33'h0);
    wr(IDX_EVT_MASK, 8'h07);
    step(1);
    chk(33'(irq), 33'h1);
    wr(IDX_FRAG_1, 8'h02);
    wr(IDX_EVT_STATUS, 8'h01);
    step(1);
    chk(33'(host_dma_request_n), 33'h0);
    xfer_go <= 1'b1;
    step(1);
    xfer_go <= 1'b0;
    step(3);
    rd(IDX_FRAG_0, 33'h4C);
    rd(IDX_FRAG_1, 33'h02);
    // a write with byte lane 0 disabled must leave the register alone
    pstrb <= 4'hE;
    wr(IDX_BUS_TIMEOUT, 8'h55);
    pstrb <= 4'hF;
    rd(IDX_BUS_TIMEOUT, 33'h0);
    // random read-back of every register of the table
    for (int i = 0; i < 7; i++) begin
      v = 8'($random(seed)) & (i == 0 ? 8'hE0 : 8'hFF);
      wr(regs[i], v);
      rd(regs[i], 33'(v));
    end
    give_verdict();
  end
  // hang guard, far beyond the roughly 1150 cycles the sequence needs
  initial begin
    step(20000);
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
